// ==== pkg/rtxc_pkg.sv ====
package rtxc_pkg;
    // Power controls held from the power register; calibration bits are separate pulse outputs.
    typedef struct packed {
        logic oscillator_power_on;
        logic converter_power_on;
        logic second_output_power_on;
        logic first_output_power_on;
        logic local_osc_output_power_on;
    } rtxc_power_t;
    // Output selection controls.
    typedef struct packed {
        logic [3:0] status_mux_select;
        logic level_high;
        logic [5:0] readback_select;
    } rtxc_outsel_t;
    // Serial receiver states.
    typedef enum logic [1:0] {
        RTXC_IDLE = 2'b01,
        RTXC_SHIFT = 2'b10
    } rtxc_state_t;
endpackage

// ==== pkg/rtxc_regs.svh ====
`ifndef RTXC_REGS_SVH
`define RTXC_REGS_SVH
// Register select codes carried in the low five bits of each word.
`define RTXC_SEL_POWER 5'h00
`define RTXC_SEL_REF 5'h01
`define RTXC_SEL_ADC 5'h02
`define RTXC_SEL_OUTSEL 5'h03
// Field positions inside the 32-bit word.
`define RTXC_SEL_HI 4
`define RTXC_BIT_CAL2 12
`define RTXC_BIT_CAL1 11
`define RTXC_BIT_OSC_PWR 10
`define RTXC_BIT_OSC_CAL 9
`define RTXC_BIT_ADC_PWR 8
`define RTXC_BIT_TX2_PWR 7
`define RTXC_BIT_TX1_PWR 6
`define RTXC_BIT_LO_PWR 5
`define RTXC_BIT_ADC_START 15
`define RTXC_AVG_HI 14
`define RTXC_AVG_LO 13
`define RTXC_CODE_HI 12
`define RTXC_CODE_LO 5
`define RTXC_MUX_HI 15
`define RTXC_MUX_LO 12
`define RTXC_LVL_BIT 11
`define RTXC_RB_HI 10
`define RTXC_RB_LO 5
// Reset values of the held fields.
`define RTXC_RST_BYTE 8'h00
`define RTXC_RST_DIV 8'h01
// Word length in bits.
`define RTXC_WORD_BITS 6'h20
`endif

// ==== rtl/rtxc_adc_clkdiv.sv ====
`timescale 1ns/100ps
`include "rtxc_regs.svh"
// Divides the reference-divider tick down to the converter sampling tick.
module rtxc_adc_clkdiv
    import rtxc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ref_tick,
    input wire logic [7:0] i_divide,
    output logic o_sample_tick
);
    logic [7:0] count;

    // Counts reference ticks; a divide of zero is treated as one so the tick never stops.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            count <= 8'h00;
            o_sample_tick <= 1'b0;
        end else begin
            o_sample_tick <= 1'b0;
            if (i_ref_tick) begin
                if (count + 8'h01 >= i_divide) begin
                    count <= 8'h00;
                    o_sample_tick <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end
endmodule

// ==== rtl/rtxc_config_regs.sv ====
`timescale 1ns/100ps
`include "rtxc_regs.svh"
module rtxc_config_regs
    import rtxc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_ser_le,
    input wire logic i_ref_tick,
    output rtxc_power_t o_power,
    output logic o_second_output_level_cal,
    output logic o_first_output_level_cal,
    output logic o_oscillator_calibrate,
    output logic [7:0] o_output_level_reference_code,
    output logic o_adc_start,
    output logic [1:0] o_adc_average,
    output logic [7:0] o_adc_divide,
    output logic o_adc_sample_tick,
    output rtxc_outsel_t o_outsel
);
    logic [2:0] clk_sync;
    logic [2:0] le_sync;
    logic [1:0] data_sync;
    logic [31:0] shift_word;
    logic [5:0] bit_count;
    logic word_done;
    logic [31:0] word;
    rtxc_state_t state;
    logic clk_rise;
    logic le_rise;
    logic le_fall;
    logic [4:0] register_select_field;

    // Pins are foreign to the system clock, so each passes two flops first.
    // The third stage only serves edge detection and reads the second.
    // The load enable chain resets to its idle high level, so no false edge follows reset.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            clk_sync <= 3'h0;
            le_sync <= 3'h7;
            data_sync <= 2'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], i_ser_clk};
            le_sync <= {le_sync[1:0], i_ser_le};
            data_sync <= {data_sync[0], i_ser_data};
        end
    end

    assign clk_rise = clk_sync[1] & ~clk_sync[2];
    assign le_rise = le_sync[1] & ~le_sync[2];
    assign le_fall = ~le_sync[1] & le_sync[2];

    // Shifts bits MSB first while the load enable is low; the word is taken on
    // the load enable rising edge only when exactly 32 bits arrived, so a short
    // or long frame is dropped rather than half-applied.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state <= RTXC_IDLE;
            shift_word <= 32'h0000_0000;
            bit_count <= 6'h00;
            word_done <= 1'b0;
            word <= 32'h0000_0000;
        end else begin
            word_done <= 1'b0;
            case (state)
                RTXC_IDLE: begin
                    if (le_fall) begin
                        bit_count <= 6'h00;
                        state <= RTXC_SHIFT;
                    end
                end
                RTXC_SHIFT: begin
                    if (le_rise) begin
                        state <= RTXC_IDLE;
                        if (bit_count == `RTXC_WORD_BITS) begin
                            word <= shift_word;
                            word_done <= 1'b1;
                        end
                    end else if (clk_rise) begin
                        shift_word <= {shift_word[30:0], data_sync[1]};
                        if (bit_count != 6'h3f) begin
                            bit_count <= bit_count + 6'h01;
                        end
                    end
                end
                default: begin
                    state <= RTXC_IDLE;
                end
            endcase
        end
    end

    // Reserved high bits are not checked; the host owns that pattern.
    assign register_select_field = word[`RTXC_SEL_HI:0];

    // Power register: levels are held, calibration bits launch one-cycle starts.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_power <= '0;
            o_second_output_level_cal <= 1'b0;
            o_first_output_level_cal <= 1'b0;
            o_oscillator_calibrate <= 1'b0;
        end else begin
            o_second_output_level_cal <= 1'b0;
            o_first_output_level_cal <= 1'b0;
            o_oscillator_calibrate <= 1'b0;
            if (word_done && register_select_field == `RTXC_SEL_POWER) begin
                o_second_output_level_cal <= word[`RTXC_BIT_CAL2];
                o_first_output_level_cal <= word[`RTXC_BIT_CAL1];
                o_power.oscillator_power_on <= word[`RTXC_BIT_OSC_PWR];
                o_oscillator_calibrate <= word[`RTXC_BIT_OSC_CAL];
                o_power.converter_power_on <= word[`RTXC_BIT_ADC_PWR];
                // Both outputs may be written on; the host is trusted here.
                o_power.second_output_power_on <= word[`RTXC_BIT_TX2_PWR];
                o_power.first_output_power_on <= word[`RTXC_BIT_TX1_PWR];
                o_power.local_osc_output_power_on <= word[`RTXC_BIT_LO_PWR];
            end
        end
    end

    // Reference code stays on the output, so any calibration sees it.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_output_level_reference_code <= `RTXC_RST_BYTE;
        end else if (word_done && register_select_field == `RTXC_SEL_REF) begin
            o_output_level_reference_code <= word[`RTXC_CODE_HI:`RTXC_CODE_LO];
        end
    end

    // Converter register: start is a one-cycle pulse per write that sets the start bit.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_adc_start <= 1'b0;
            o_adc_average <= 2'h0;
            o_adc_divide <= `RTXC_RST_DIV;
        end else begin
            o_adc_start <= 1'b0;
            if (word_done && register_select_field == `RTXC_SEL_ADC) begin
                o_adc_start <= word[`RTXC_BIT_ADC_START];
                o_adc_average <= word[`RTXC_AVG_HI:`RTXC_AVG_LO];
                o_adc_divide <= word[`RTXC_CODE_HI:`RTXC_CODE_LO];
            end
        end
    end

    // Output select register.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_outsel <= '0;
        end else if (word_done && register_select_field == `RTXC_SEL_OUTSEL) begin
            o_outsel.status_mux_select <= word[`RTXC_MUX_HI:`RTXC_MUX_LO];
            o_outsel.level_high <= word[`RTXC_LVL_BIT];
            o_outsel.readback_select <= word[`RTXC_RB_HI:`RTXC_RB_LO];
        end
    end

    // Sampling clock divider driven from the reference tick.
    rtxc_adc_clkdiv u_clkdiv (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_ref_tick(i_ref_tick),
        .i_divide(o_adc_divide),
        .o_sample_tick(o_adc_sample_tick)
    );

    // Checks.
    property p_ref_update;
        @(posedge i_sys_clk) disable iff (i_srst)
        (word_done && register_select_field == `RTXC_SEL_REF)
            |=> o_output_level_reference_code == $past(word[12:5]);
    endproperty
    a_ref_update: assert property (p_ref_update) else $error("ref code not loaded");

    property p_start_pulse;
        @(posedge i_sys_clk) disable iff (i_srst)
        o_adc_start |=> !o_adc_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");

    property p_cal_cause;
        @(posedge i_sys_clk) disable iff (i_srst)
        $rose(o_oscillator_calibrate) |-> $past(word_done) && $past(word[9])
            && $past(register_select_field) == `RTXC_SEL_POWER;
    endproperty
    a_cal_cause: assert property (p_cal_cause) else $error("calibrate without write");

    property p_mux_hold;
        @(posedge i_sys_clk) disable iff (i_srst)
        !$past(word_done) |-> $stable(o_outsel);
    endproperty
    a_mux_hold: assert property (p_mux_hold) else $error("select changed w/o write");

    property p_full_word;
        @(posedge i_sys_clk) disable iff (i_srst)
        word_done |-> $past(bit_count) == 6'h20;
    endproperty
    a_full_word: assert property (p_full_word) else $error("short word applied");

    // A committed word aimed at the power register.
    sequence s_power_write;
        word_done && register_select_field == `RTXC_SEL_POWER;
    endsequence

    property p_cal2_launch;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_power_write ##0 word[`RTXC_BIT_CAL2] |=> o_second_output_level_cal;
    endproperty
    a_cal2_launch: assert property (p_cal2_launch) else $error("second cal not launched");

    property p_cal1_launch;
        @(posedge i_sys_clk) disable iff (i_srst)
        s_power_write ##0 word[`RTXC_BIT_CAL1] |=> o_first_output_level_cal;
    endproperty
    a_cal1_launch: assert property (p_cal1_launch) else $error("first cal not launched");
endmodule

// ==== verif/rtxc_host_model.sv ====
`timescale 1ns/100ps
// Host side of the serial link: frames of up to 32 bits, MSB first, clock idle low between frames.
module rtxc_host_model (
    input wire logic i_sys_clk,
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_ser_le
);
    // Reserved pattern of the reference register; the other registers use zeros.
    localparam logic [31:0] RSV_REF = 32'hFFF7_E000;
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_ser_le = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Short frames exist only so that the bench can see them dropped.
    task automatic send(input logic [31:0] word, input int nbits);
        logic [31:0] w;
        w = word;
        if (word[4:0] == 5'h01) w = word | RSV_REF;
        step(1);
        o_ser_le = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            step(4);
            o_ser_data = w[i];
            step(4);
            o_ser_clk = 1'b1;
            step(4);
            o_ser_clk = 1'b0;
        end
        step(4);
        o_ser_le = 1'b1;
        // A released data line must not keep showing the last bit.
        o_ser_data = ~o_ser_data;
        step(2);
    endtask
endmodule

// ==== verif/test_radar_tx_config_registers_r0_r3.sv ====
`timescale 1ns/100ps
module test_radar_tx_config_registers_r0_r3;
    import rtxc_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_ref_tick = 1'b0;
    logic ser_clk;
    logic ser_data;
    logic ser_le;
    rtxc_power_t o_power;
    logic o_cal2;
    logic o_cal1;
    logic o_oscc;
    logic [7:0] o_code;
    logic o_start;
    logic [1:0] o_avg;
    logic [7:0] o_div;
    logic o_tick;
    rtxc_outsel_t o_outsel;
    int fail_count = 0;
    int checks_done = 0;
    int n_cal2 = 0;
    int n_cal1 = 0;
    int n_oscc = 0;
    int n_start = 0;
    int ref_cnt = 0;
    rtxc_config_regs dut_u (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_ser_clk(ser_clk),
        .i_ser_data(ser_data), .i_ser_le(ser_le), .i_ref_tick(i_ref_tick), .o_power(o_power),
        .o_second_output_level_cal(o_cal2), .o_first_output_level_cal(o_cal1),
        .o_oscillator_calibrate(o_oscc), .o_output_level_reference_code(o_code),
        .o_adc_start(o_start), .o_adc_average(o_avg), .o_adc_divide(o_div),
        .o_adc_sample_tick(o_tick), .o_outsel(o_outsel));
    rtxc_host_model host_u (.i_sys_clk(i_sys_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
        .o_ser_le(ser_le));
    // Clock at 125 MHz.
    always #4 i_sys_clk = ~i_sys_clk;
    // Reference divider pulse every fifth cycle; a divide of 25 then gives 125 cycles,
    // which is the 1 MHz sampling rate at the 125 MHz system clock.
    always @(posedge i_sys_clk) begin
        #1;
        ref_cnt = (ref_cnt + 1) % 5;
        i_ref_tick = (ref_cnt == 0);
    end
    // Pulses last one cycle, so they are counted rather than looked for at a fixed moment.
    always @(posedge i_sys_clk) begin
        if (o_cal2 === 1'b1) n_cal2++;
        if (o_cal1 === 1'b1) n_cal1++;
        if (o_oscc === 1'b1) n_oscc++;
        if (o_start === 1'b1) n_start++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [31:0] w, input int nbits);
        host_u.send(w, nbits);
        repeat (10) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic t_reset();
        check(o_power, 5'b0_0000);
        check(o_code, 8'h00);
        check(o_div, 8'h01);
        check({o_avg, o_outsel}, 13'h0000);
    endtask
    task automatic t_power();
        int c2;
        int c1;
        int oc;
        c2 = n_cal2;
        c1 = n_cal1;
        oc = n_oscc;
        put(32'h0000_1580, 32);
        check(o_power, 5'b1_1100);
        check(n_cal2 - c2, 1);
        check(n_cal1 - c1, 0);
        check(n_oscc - oc, 0);
        put(32'h0000_0A60, 32);
        check(o_power, 5'b0_0011);
        check(n_cal2 - c2, 1);
        check(n_cal1 - c1, 1);
        check(n_oscc - oc, 1);
    endtask
    task automatic t_ref();
        put(32'h0000_14A1, 32);
        check(o_code, 8'hA5);
        check(o_power, 5'b0_0011);
    endtask
    task automatic t_adc();
        int s;
        int k;
        s = n_start;
        put(32'h0000_C322, 32);
        check(n_start - s, 1);
        check(o_avg, 2'b10);
        check(o_div, 8'h19);
        k = 0;
        while (o_tick !== 1'b1 && k < 300) begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end
        k = 0;
        do begin
            @(posedge i_sys_clk);
            #1;
            k++;
        end while (o_tick !== 1'b1 && k < 300);
        check(k, 125);
        put(32'h0000_0062, 32);
        check(n_start - s, 1);
    endtask
    task automatic t_outsel();
        put(32'h0000_AD63, 32);
        check(o_outsel, {4'hA, 1'b1, 6'h2B});
        put(32'h0000_0FE3, 31);
        check(o_outsel, {4'hA, 1'b1, 6'h2B});
        put(32'h0000_1FE4, 32);
        check({o_outsel, o_code, o_power}, {4'hA, 1'b1, 6'h2B, 8'hA5, 5'b0_0011});
    endtask
    task automatic results();
        if (fail_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run is eight frames of roughly 400 cycles each.
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        repeat (5) @(posedge i_sys_clk);
        #1;
        i_srst = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        t_reset();
        t_power();
        t_ref();
        t_adc();
        t_outsel();
        results();
    end
endmodule
